// ===== common/homing_pkg.sv
/*
 * constants, register map and types for the per-axis origin tracker and homing sequencer.
 * assumes an ahb-lite master with word transfers and a fieldbus stack that carries drive objects.
 */
// Contract
// - homing start clears origin, success sets it
// - set-position loads value, marks origin determined
// - readable origin-determined flag for every axis
// - absolute encoder: reconnect keeps prior origin status
// - incremental: drive power loss clears origin
// - incremental: controller power cycle clears origin
// - failed or aborted homing leaves origin undetermined
// - refuse absolute moves without determined origin
// - ignore origin sensor once origin determined
// - drive performs motion, controller commands and monitors
// - execute rising edge; done/busy/active/aborted/error/code outputs
// - homing position input becomes user origin
// - method 0x6098, speeds 0x6099:1/2, accel 0x609A
// - 8 inputs, 16 outputs, 64 stations expansion
package homing_pkg;
    localparam int NUM_AXES = 4;                    // axes served by this block
    localparam int AXIS_W   = 2;                    // axis number width
    localparam int NUM_CFG  = 4;                    // drive objects written per axis
    // i/o capacity of the controller, reported to software
    localparam logic [7:0]  INT_INPUTS   = 8'h08;
    localparam logic [7:0]  INT_OUTPUTS  = 8'h10;
    localparam logic [7:0]  EXT_STATIONS = 8'h40;
    // register byte offsets
    localparam logic [7:0] OFS_COMMAND  = 8'h00;
    localparam logic [7:0] OFS_GROUP    = 8'h04;
    localparam logic [7:0] OFS_HOME_POS = 8'h08;
    localparam logic [7:0] OFS_SET_POS  = 8'h0C;
    localparam logic [7:0] OFS_ENCODER  = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_ERROR    = 8'h18;
    localparam logic [7:0] OFS_AXIS_POS = 8'h1C;
    localparam logic [7:0] OFS_METHOD   = 8'h20;
    localparam logic [7:0] OFS_SPD_SW   = 8'h24;
    localparam logic [7:0] OFS_SPD_ZERO = 8'h28;
    localparam logic [7:0] OFS_ACCEL    = 8'h2C;
    localparam logic [7:0] OFS_IO_CAP   = 8'h30;
    // command register fields
    localparam int CMD_AXIS_LSB = 0;
    localparam int CMD_HOME     = 4;
    localparam int CMD_GROUP    = 5;
    localparam int CMD_SETPOS   = 6;
    localparam int CMD_MOVE     = 7;
    // status register fields (origin flags sit at the bottom)
    localparam int ST_DONE    = 8;
    localparam int ST_BUSY    = 9;
    localparam int ST_ACTIVE  = 10;
    localparam int ST_ABORTED = 11;
    localparam int ST_ERROR   = 12;
    localparam int ST_REFUSED = 13;
    // drive object dictionary
    localparam logic [15:0] OBJ_METHOD = 16'h6098;
    localparam logic [15:0] OBJ_SPEEDS = 16'h6099;
    localparam logic [15:0] OBJ_ACCEL  = 16'h609A;
    localparam logic [7:0]  SUB_NONE   = 8'h00;
    localparam logic [7:0]  SUB_SWITCH = 8'h01;
    localparam logic [7:0]  SUB_ZERO   = 8'h02;
    // encoder selection value meaning absolute
    localparam logic ENC_ABSOLUTE = 1'b1;
    // error numbers
    localparam logic [15:0] ERR_NONE    = 16'h0000;
    localparam logic [15:0] ERR_FAULT   = 16'h0001;
    localparam logic [15:0] ERR_LINK    = 16'h0002;
    localparam logic [15:0] ERR_NO_AXIS = 16'h0003;
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    typedef enum logic [1:0] {H_IDLE, H_CONFIG, H_START, H_WAIT} home_state_type;
endpackage

// ===== rtl/origin_homing_status_control.sv
/*
 * per-axis origin tracker and homing sequencer behind an ahb-lite register slave.
 * assumes a fieldbus stack on clk that writes drive objects and reports homing status;
 * link state, origin sensors and the battery-backed origin memory arrive from pins.
 */
`timescale 1ns/100ps
module origin_homing_status_control (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            reset,
    // ahb-lite slave
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic [31:0]                          hrdata,
    output logic                                 hresp,
    // drive object writes
    output logic                                 obj_valid,
    output logic [homing_pkg::AXIS_W-1:0]        obj_axis,
    output logic [15:0]                          obj_index,
    output logic [7:0]                           obj_subindex,
    output logic [31:0]                          obj_data,
    input  wire logic                            obj_ack,
    // homing handshake with the drives
    output logic [homing_pkg::NUM_AXES-1:0]      homing_start,
    input  wire logic [homing_pkg::NUM_AXES-1:0] homing_attained,
    input  wire logic [homing_pkg::NUM_AXES-1:0] homing_fault,
    input  wire logic [homing_pkg::NUM_AXES*32-1:0] encoder_position,
    // pins from outside
    input  wire logic [homing_pkg::NUM_AXES-1:0] drive_link_up,
    input  wire logic [homing_pkg::NUM_AXES-1:0] origin_sensor,
    input  wire logic [homing_pkg::NUM_AXES-1:0] retained_origin,
    // results
    output logic [homing_pkg::NUM_AXES-1:0]      axis_origin_determined_flag,
    output logic [homing_pkg::NUM_AXES-1:0]      sensor_capture,
    output logic                                 move_grant
);
    localparam int NA = homing_pkg::NUM_AXES;

    // one-hot decode of an axis number, used for several commands
    function automatic logic [NA-1:0] axis_onehot(input logic [homing_pkg::AXIS_W-1:0] a);
        axis_onehot = '0;
        axis_onehot[a] = 1'b1;
    endfunction

    // software registers
    logic [7:0]                  cmd_q;          // command levels and axis number
    logic [7:0]                  cmd_prev_q;     // last command, for edges
    logic [NA-1:0]               group_q;        // axis_group_select
    logic [31:0]                 home_pos_q;     // user origin for homing
    logic [31:0]                 set_pos_q;      // value for set_current_position_command
    logic [NA-1:0]               enc_sel_q;      // encoder selection per axis
    logic [7:0]                  method_q;       // signed homing method
    logic [31:0]                 spd_sw_q;       // switch search speed
    logic [31:0]                 spd_zero_q;     // zero search speed
    logic [31:0]                 accel_q;        // homing acceleration
    // bus data phase
    logic                        wr_pend_q;      // write data expected
    logic [7:0]                  wr_addr_q;      // write offset
    // sequencer state
    homing_pkg::home_state_type  state_q;
    logic [NA-1:0]               mask_q;         // axes in the running homing
    logic [homing_pkg::AXIS_W-1:0] cfg_axis_q;   // axis being configured
    logic [1:0]                  cfg_step_q;     // object within that axis
    logic                        done_q;
    logic                        aborted_q;
    logic                        error_q;
    logic [15:0]                 err_num_q;
    logic                        refused_q;      // last absolute move refused
    logic [31:0]                 abs_pos_q [NA]; // absolute position per axis
    // synchronised pins
    logic [NA-1:0]               link_lvl;
    logic [NA-1:0]               link_rise;
    logic [NA-1:0]               sensor_rise;
    logic [NA-1:0]               retain_lvl;

    // every pin crosses into clk through two flops first
    pin_sync_rise #(.W(NA)) u_link (
        .clk   (clk),
        .reset (reset),
        .pin   (drive_link_up),
        .level (link_lvl),
        .rise  (link_rise)
    );
    pin_sync_rise #(.W(NA)) u_sensor (
        .clk   (clk),
        .reset (reset),
        .pin   (origin_sensor),
        .level (),
        .rise  (sensor_rise)
    );
    pin_sync_rise #(.W(NA)) u_retain (
        .clk   (clk),
        .reset (reset),
        .pin   (retained_origin),
        .level (retain_lvl),
        .rise  ()
    );

    // bus decode
    wire        addr_phase = hsel & htrans[1] & hready;
    wire        rd_take    = addr_phase & ~hwrite;
    wire [7:0]  rd_ofs     = haddr[7:0];
    wire        wr_now     = wr_pend_q;
    // command edges, taken only on rising execute levels
    wire [7:0]  cmd_rise   = cmd_q & ~cmd_prev_q;
    wire [homing_pkg::AXIS_W-1:0] sel_axis = cmd_q[homing_pkg::CMD_AXIS_LSB +: homing_pkg::AXIS_W];
    wire [NA-1:0] sel_hot  = axis_onehot(sel_axis);
    wire        home_go    = cmd_rise[homing_pkg::CMD_HOME] | cmd_rise[homing_pkg::CMD_GROUP];
    // only connected axes take part
    wire [NA-1:0] req_mask = (cmd_rise[homing_pkg::CMD_GROUP] ? group_q : sel_hot) & link_lvl;
    wire        busy       = state_q != homing_pkg::H_IDLE;
    wire        cfg_last   = cfg_step_q == 2'(homing_pkg::NUM_CFG - 1);
    wire [NA-1:0] cfg_hot  = axis_onehot(cfg_axis_q);
    wire        cfg_in     = |(cfg_hot & mask_q);
    wire        all_done   = &(homing_attained | ~mask_q);
    wire        any_fault  = |(homing_fault & mask_q);
    wire        link_lost  = |(~link_lvl & mask_q);
    // homing finished well: origin set on these axes
    wire [NA-1:0] set_mask = (state_q == homing_pkg::H_WAIT && !home_go && !any_fault && !link_lost && all_done)
                             ? mask_q : '0;
    wire [NA-1:0] clr_mask = home_go ? req_mask : '0;
    wire [NA-1:0] sp_mask  = cmd_rise[homing_pkg::CMD_SETPOS] ? sel_hot : '0;
    // object payload per configuration step
    wire [15:0] step_index = (cfg_step_q == 2'd0) ? homing_pkg::OBJ_METHOD :
                             (cfg_step_q == 2'd3) ? homing_pkg::OBJ_ACCEL : homing_pkg::OBJ_SPEEDS;
    wire [7:0]  step_sub   = (cfg_step_q == 2'd1) ? homing_pkg::SUB_SWITCH :
                             (cfg_step_q == 2'd2) ? homing_pkg::SUB_ZERO : homing_pkg::SUB_NONE;
    wire [31:0] step_data  = (cfg_step_q == 2'd0) ? {{24{method_q[7]}}, method_q} :
                             (cfg_step_q == 2'd1) ? spd_sw_q :
                             (cfg_step_q == 2'd2) ? spd_zero_q : accel_q;
    // status word
    wire [31:0] status_w   = {18'h0, refused_q, error_q, aborted_q, state_q == homing_pkg::H_WAIT, busy, done_q,
                              {(8-NA){1'b0}}, axis_origin_determined_flag};
    wire [31:0] rd_mux     = (rd_ofs == homing_pkg::OFS_COMMAND)  ? {24'h0, cmd_q} :
                             (rd_ofs == homing_pkg::OFS_GROUP)    ? {{(32-NA){1'b0}}, group_q} :
                             (rd_ofs == homing_pkg::OFS_HOME_POS) ? home_pos_q :
                             (rd_ofs == homing_pkg::OFS_SET_POS)  ? set_pos_q :
                             (rd_ofs == homing_pkg::OFS_ENCODER)  ? {{(32-NA){1'b0}}, enc_sel_q} :
                             (rd_ofs == homing_pkg::OFS_STATUS)   ? status_w :
                             (rd_ofs == homing_pkg::OFS_ERROR)    ? {16'h0, err_num_q} :
                             (rd_ofs == homing_pkg::OFS_AXIS_POS) ? abs_pos_q[sel_axis] :
                             (rd_ofs == homing_pkg::OFS_METHOD)   ? {24'h0, method_q} :
                             (rd_ofs == homing_pkg::OFS_SPD_SW)   ? spd_sw_q :
                             (rd_ofs == homing_pkg::OFS_SPD_ZERO) ? spd_zero_q :
                             (rd_ofs == homing_pkg::OFS_ACCEL)    ? accel_q :
                             (rd_ofs == homing_pkg::OFS_IO_CAP)   ? {8'h0, homing_pkg::EXT_STATIONS,
                                 homing_pkg::INT_OUTPUTS, homing_pkg::INT_INPUTS} :
                             homing_pkg::RESET_WORD;

    // bus slave: zero wait states, always okay
    // no register needs a wait state, so hreadyout never drops
    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= homing_pkg::RESET_WORD;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            wr_addr_q <= haddr[7:0];
            // read data captured at the address phase, unmapped reads zero
            if (rd_take) begin
                hrdata <= rd_mux;
            end
        end
    end

    // software-written registers; unmapped writes dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_q      <= 8'h00;
            cmd_prev_q <= 8'h00;
            group_q    <= '0;
            home_pos_q <= homing_pkg::RESET_WORD;
            set_pos_q  <= homing_pkg::RESET_WORD;
            enc_sel_q  <= '0;
            method_q   <= 8'h00;
            spd_sw_q   <= homing_pkg::RESET_WORD;
            spd_zero_q <= homing_pkg::RESET_WORD;
            accel_q    <= homing_pkg::RESET_WORD;
        end else begin
            cmd_prev_q <= cmd_q;
            if (wr_now && wr_addr_q == homing_pkg::OFS_COMMAND)  cmd_q      <= hwdata[7:0];
            if (wr_now && wr_addr_q == homing_pkg::OFS_GROUP)    group_q    <= hwdata[NA-1:0];
            if (wr_now && wr_addr_q == homing_pkg::OFS_HOME_POS) home_pos_q <= hwdata;
            if (wr_now && wr_addr_q == homing_pkg::OFS_SET_POS)  set_pos_q  <= hwdata;
            if (wr_now && wr_addr_q == homing_pkg::OFS_ENCODER)  enc_sel_q  <= hwdata[NA-1:0];
            if (wr_now && wr_addr_q == homing_pkg::OFS_METHOD)   method_q   <= hwdata[7:0];
            if (wr_now && wr_addr_q == homing_pkg::OFS_SPD_SW)   spd_sw_q   <= hwdata;
            if (wr_now && wr_addr_q == homing_pkg::OFS_SPD_ZERO) spd_zero_q <= hwdata;
            if (wr_now && wr_addr_q == homing_pkg::OFS_ACCEL)    accel_q    <= hwdata;
        end
    end

    // homing sequencer: configure each axis in the request, start, then watch the drives
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q      <= homing_pkg::H_IDLE;
            mask_q       <= '0;
            cfg_axis_q   <= '0;
            cfg_step_q   <= 2'd0;
            homing_start <= '0;
            obj_valid    <= 1'b0;
            done_q       <= 1'b0;
            aborted_q    <= 1'b0;
            error_q      <= 1'b0;
            err_num_q    <= homing_pkg::ERR_NONE;
        end else if (home_go) begin
            // a new command replaces a running one, which reports aborted
            // start requests drop at once so no drive keeps homing
            aborted_q    <= busy;
            done_q       <= 1'b0;
            homing_start <= '0;
            obj_valid    <= 1'b0;
            mask_q       <= req_mask;
            cfg_axis_q   <= '0;
            cfg_step_q   <= 2'd0;
            error_q      <= ~|req_mask;
            err_num_q    <= (|req_mask) ? homing_pkg::ERR_NONE : homing_pkg::ERR_NO_AXIS;
            state_q      <= (|req_mask) ? homing_pkg::H_CONFIG : homing_pkg::H_IDLE;
        end else begin
            case (state_q)
                homing_pkg::H_IDLE: begin
                    obj_valid <= 1'b0;
                end
                homing_pkg::H_CONFIG: begin
                    // drive parameters go out before any start request
                    if (!cfg_in) begin
                        cfg_step_q <= 2'd0;
                        cfg_axis_q <= cfg_axis_q + 1'b1;
                        if (cfg_axis_q == homing_pkg::AXIS_W'(NA - 1)) state_q <= homing_pkg::H_START;
                    end else if (!obj_valid) begin
                        obj_valid <= 1'b1;
                    end else if (obj_ack) begin
                        obj_valid  <= 1'b0;
                        cfg_step_q <= cfg_step_q + 1'b1;
                        if (cfg_last) begin
                            cfg_step_q <= 2'd0;
                            cfg_axis_q <= cfg_axis_q + 1'b1;
                            if (cfg_axis_q == homing_pkg::AXIS_W'(NA - 1)) state_q <= homing_pkg::H_START;
                        end
                    end
                end
                homing_pkg::H_START: begin
                    homing_start <= mask_q;
                    state_q      <= homing_pkg::H_WAIT;
                end
                homing_pkg::H_WAIT: begin
                    // drive moves on its own; we only watch its status
                    if (any_fault || link_lost) begin
                        error_q      <= 1'b1;
                        err_num_q    <= any_fault ? homing_pkg::ERR_FAULT : homing_pkg::ERR_LINK;
                        homing_start <= '0;
                        state_q      <= homing_pkg::H_IDLE;
                    end else if (all_done) begin
                        done_q       <= 1'b1;
                        homing_start <= '0;
                        state_q      <= homing_pkg::H_IDLE;
                    end
                end
                default: begin
                    state_q <= homing_pkg::H_IDLE;
                end
            endcase
        end
    end

    // drive object payload follows the current step
    always_ff @(posedge clk) begin
        if (reset) begin
            obj_axis     <= '0;
            obj_index    <= 16'h0000;
            obj_subindex <= homing_pkg::SUB_NONE;
            obj_data     <= homing_pkg::RESET_WORD;
        end else if (!obj_valid) begin
            obj_axis     <= cfg_axis_q;
            obj_index    <= step_index;
            obj_subindex <= step_sub;
            obj_data     <= step_data;
        end
    end

    // per-axis origin flag and absolute position; set requests win over clears
    generate
        for (genvar i = 0; i < NA; i++) begin : g_axis
            wire enc_abs = enc_sel_q[i] == homing_pkg::ENC_ABSOLUTE;
            always_ff @(posedge clk) begin
                if (reset) begin
                    // controller power cycle: every axis, absolute or incremental, starts undetermined
                    axis_origin_determined_flag[i] <= 1'b0;
                    abs_pos_q[i]                   <= homing_pkg::RESET_WORD;
                    sensor_capture[i]              <= 1'b0;
                end else begin
                    if (clr_mask[i]) axis_origin_determined_flag[i] <= 1'b0;
                    if (link_rise[i]) begin
                        if (enc_abs) begin
                            // position rebuilt from the encoder, prior status kept
                            abs_pos_q[i] <= encoder_position[i*32 +: 32];
                            axis_origin_determined_flag[i] <= axis_origin_determined_flag[i] | retain_lvl[i];
                        end else begin
                            axis_origin_determined_flag[i] <= 1'b0;
                        end
                    end
                    if (set_mask[i]) begin
                        // homing position input is the user origin, no drive offset
                        abs_pos_q[i]                   <= home_pos_q;
                        axis_origin_determined_flag[i] <= 1'b1;
                    end
                    if (sp_mask[i]) begin
                        abs_pos_q[i]                   <= set_pos_q;
                        axis_origin_determined_flag[i] <= 1'b1;
                    end
                    // sensor only matters while this axis is still looking for home
                    // an axis homed in this very cycle is already past its sensor
                    sensor_capture[i] <= sensor_rise[i] & homing_start[i] & ~(set_mask[i] | sp_mask[i])
                                         & ~axis_origin_determined_flag[i];
                end
            end
        end
    endgenerate

    // absolute move gate on the selected axis
    // refusal stays in status until the next move request
    always_ff @(posedge clk) begin
        if (reset) begin
            move_grant <= 1'b0;
            refused_q  <= 1'b0;
        end else begin
            move_grant <= cmd_rise[homing_pkg::CMD_MOVE] & axis_origin_determined_flag[sel_axis];
            if (cmd_rise[homing_pkg::CMD_MOVE]) begin
                refused_q <= ~axis_origin_determined_flag[sel_axis];
            end
        end
    end
endmodule // origin_homing_status_control

// ===== rtl/pin_sync_rise.sv
/*
 * two-stage synchroniser with rising edge detect for a group of pins.
 * assumes pins are asynchronous to clk; reset is synchronous, active high.
 */
`timescale 1ns/100ps
module pin_sync_rise #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // pins and results
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_q;   // first stage, read only by level
    logic [W-1:0] prev_q;   // last stable value for edge detect

    // metastability stages, then one more for the edge
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            level  <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin;
            level  <= meta_q;
            prev_q <= level;
        end
    end

    // edge taken from stable stages only
    assign rise = level & ~prev_q;
endmodule // pin_sync_rise

// ===== verif/drive_model.sv
/* behavioural servo drive on the fieldbus side.
   assumes the controller's clock; fail is set by the bench. */
`timescale 1ns/100ps
module drive_model (
    input wire logic       clk, reset, fail, obj_valid,
    input wire logic [3:0] homing_start,
    output logic           obj_ack,
    output logic [3:0]     homing_attained, homing_fault
);
    logic [3:0] cnt_q; // homing progress, drive does the motion itself
    // random ack wait keeps parameters configured first report attained or fault
    always_ff @(posedge clk) begin
        if (reset) begin
            {obj_ack, cnt_q, homing_attained, homing_fault} <= 13'h0;
        end else begin
            obj_ack         <= obj_valid && !obj_ack && 1'($urandom_range(1));
            cnt_q           <= (homing_start == 4'h0) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
            homing_attained <= (cnt_q == 4'hF && !fail) ? homing_start : 4'h0;
            homing_fault    <= (cnt_q == 4'hF && fail) ? homing_start : 4'h0;
        end
    end
endmodule // drive_model

// ===== verif/origin_homing_status_control_bench.sv
/* self-checking bench for the origin tracker.
   assumes the drive model answers on the fieldbus side. */
`timescale 1ns/100ps
module origin_homing_status_control_bench;
    logic clk = 0, reset = 1, hsel = 0, hwrite = 0, fail = 0, hreadyout, hresp, obj_valid, obj_ack, move_grant;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v, obj_data;
    logic [1:0] htrans = 0, obj_axis;
    logic [2:0] hsize = 3'h2;
    logic [15:0] obj_index;
    logic [7:0] obj_subindex;
    logic [3:0] homing_start, homing_attained, homing_fault, drive_link_up = 0, origin_sensor = 0;
    logic [3:0] retained_origin = 0, axis_origin_determined_flag, sensor_capture;
    logic [127:0] encoder_position = 0;
    int fails = 0, n_tests = 0, grants = 0;
    always #5 clk = ~clk;
    // count grant pulses, toggle sensors at random
    always @(posedge clk) begin
        grants <= grants + int'(move_grant);
        origin_sensor <= 4'($urandom);
    end
    origin_homing_status_control DUT (.*, .hready(hreadyout));
    drive_model u_drive (.*);
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task chk(input string s, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", s, exp, seen);
        end
    endtask
    // commands act on a rising bit, so rearm with axis kept
    task cmd(input logic [31:0] c);
        bus(1, 8'h00, c); bus(1, 8'h00, c & 32'h3); repeat (3) @(posedge clk);
    endtask
    task st_wait;
        bus(0, 8'h14, 0);
        for (int i = 0; i < 300 && rd[9] !== 1'b0; i++) bus(0, 8'h14, 0);
    endtask
    task link(input logic [3:0] m);
        drive_link_up <= ~m; repeat (4) @(posedge clk); drive_link_up <= 4'hF; repeat (5) @(posedge clk);
    endtask
    task results;
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h197C1E97));
        repeat (10) @(posedge clk);
        reset <= 0; drive_link_up <= 4'hF; repeat (4) @(posedge clk);
        bus(0, 8'h30, 0); chk("caps", rd, 32'h0040_1008);
        bus(0, 8'h3C, 0); chk("unmapped", rd, 0);
        cmd(32'h80); bus(0, 8'h14, 0); chk("refused", rd[13], 1); chk("flags", rd[3:0], 0);
        v = $urandom; bus(1, 8'h0C, v); cmd(32'h41); bus(0, 8'h1C, 0); chk("setpos", rd, v);
        bus(1, 8'h20, 32'h22); v = $urandom; bus(1, 8'h08, v); cmd(32'h12); st_wait;
        chk("done", rd[12:0], 13'h0106);
        bus(0, 8'h1C, 0); chk("origin", rd, v);
        fail <= 1; bus(1, 8'h04, 32'h3); cmd(32'h13);
        do bus(0, 8'h14, 0); while (rd[10] !== 1'b1);
        cmd(32'h20); st_wait; chk("fault", rd[12:0], 13'h1804);
        bus(0, 8'h18, 0); chk("errnum", rd, 1);
        fail <= 0; bus(1, 8'h04, 0); cmd(32'h20); bus(0, 8'h18, 0); chk("empty", rd, 3);
        link(4'h4); bus(0, 8'h14, 0); chk("incr", rd[3:0], 0);
        cmd(32'h43); bus(1, 8'h10, 32'h8); retained_origin <= 4'h8; encoder_position <= {$urandom, 96'h0};
        link(4'h8); bus(0, 8'h1C, 0); chk("abspos", rd, encoder_position[127:96]);
        bus(0, 8'h14, 0); chk("absflag", rd[3:0], 4'h8);
        cmd(32'h83); chk("grant", grants, 1);
        reset <= 1; repeat (10) @(posedge clk); reset <= 0; repeat (4) @(posedge clk);
        bus(0, 8'h14, 0); chk("ctlreset", rd[3:0], 0);
        results;
    end
    initial begin
        #300000;
        fails++;
        results;
    end
endmodule // origin_homing_status_control_bench

// ===== verif/origin_homing_status_control_props.sv
/* checker on the tracker's top ports.
   assumes it is bound onto the top module. */
`timescale 1ns/100ps
module origin_homing_props (
    input wire logic        clk, reset, hreadyout, hresp, move_grant, obj_valid, obj_ack,
    input wire logic [15:0] obj_index,
    input wire logic [7:0]  obj_subindex,
    input wire logic [31:0] obj_data,
    input wire logic [3:0]  homing_start, homing_attained, homing_fault,
    input wire logic [3:0]  axis_origin_determined_flag, sensor_capture
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    chk_grant_flag: assert property (move_grant |-> (|axis_origin_determined_flag) ##1 !move_grant)
        else $error("move granted without origin");
    chk_start_clear: assert property ((homing_start & axis_origin_determined_flag) == 4'h0)
        else $error("origin set while homing");
    chk_obj_hold: assert property (obj_valid && !obj_ack |=> obj_valid && $stable(obj_index) && $stable(obj_data))
        else $error("object write not held");
    chk_obj_index: assert property (obj_valid |-> obj_index inside {16'h6098, 16'h6099, 16'h609A})
        else $error("bad object index");
    chk_obj_sub: assert property (obj_valid |-> (obj_index == 16'h6099) == (obj_subindex != 8'h00))
        else $error("bad object subindex");
    chk_sense_ignore: assert property (sensor_capture |-> (sensor_capture & axis_origin_determined_flag) == 4'h0)
        else $error("sensor seen on homed axis");
    chk_done_sets: assert property (homing_start != 4'h0 && (homing_attained & homing_start) == homing_start
        && (homing_fault & homing_start) == 4'h0 |=> homing_start == 4'h0
        && (axis_origin_determined_flag & $past(homing_start)) == $past(homing_start))
        else $error("homing success not finished");
    chk_fault_undet: assert property ((homing_start & homing_fault) != 4'h0 |=> homing_start == 4'h0
        && (axis_origin_determined_flag & $past(homing_start)) == 4'h0)
        else $error("failed homing left origin");
endmodule // origin_homing_props
bind origin_homing_status_control origin_homing_props u_props (.*);
